// ---- shared/stm_pkg.sv ----
package stm_pkg;
    // ========================================
    // bus and register map
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL0 = 8'h00;
    localparam logic [7:0] OFS_CTRL1 = 8'h04;
    localparam logic [7:0] OFS_CNT_LO = 8'h08;
    localparam logic [7:0] OFS_CNT_HI = 8'h0C;
    localparam logic [7:0] OFS_CMPA_LO = 8'h10;
    localparam logic [7:0] OFS_CMPA_HI = 8'h14;
    localparam logic [7:0] OFS_PERIOD = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    // ========================================
    // field positions
    localparam int C0_PAUSE = 7;
    localparam int C0_CKS_LSB = 4;
    localparam int C0_ON = 3;
    localparam int C1_MODE_LSB = 6;
    localparam int C1_FN_LSB = 4;
    localparam int C1_OC = 3;
    localparam int C1_POL = 2;
    localparam int C1_SWAP = 1;
    localparam int C1_CCLR = 0;
    localparam int ST_A = 0;
    localparam int ST_P = 1;
    // ========================================
    // reset values
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;
    // ========================================
    // timing counts
    localparam logic [1:0] DIV4_END = 2'h3;
    localparam logic [3:0] DIV16_END = 4'hF;
    localparam logic [5:0] DIV64_END = 6'h3F;
    // subclock stands in as a slow divider of CLK
    localparam logic [15:0] SUB_DIV_END = 16'h03E7;
    localparam logic [16:0] FULL_SPAN = 17'h10000;
    // ========================================
    // encodings
    typedef enum logic [1:0] {
        MODE_CMP = 2'b00,
        MODE_CAP = 2'b01,
        MODE_PWM = 2'b10,
        MODE_TMR = 2'b11
    } mode_t;
    localparam logic [1:0] FN_NONE = 2'b00;
    localparam logic [1:0] FN_LOW = 2'b01;
    localparam logic [1:0] FN_HIGH = 2'b10;
    localparam logic [1:0] FN_TOGGLE = 2'b11;
    localparam logic [1:0] FN_INACT = 2'b00;
    localparam logic [1:0] FN_ACT = 2'b01;
    localparam logic [1:0] FN_PWM = 2'b10;
    localparam logic [2:0] CKS_SYS4 = 3'b000;
    localparam logic [2:0] CKS_SYS = 3'b001;
    localparam logic [2:0] CKS_H16 = 3'b010;
    localparam logic [2:0] CKS_H64 = 3'b011;
    localparam logic [2:0] CKS_SUB0 = 3'b100;
    localparam logic [2:0] CKS_SUB1 = 3'b101;
    localparam logic [2:0] CKS_EXTR = 3'b110;
    localparam logic [2:0] CKS_EXTF = 3'b111;
endpackage

// ---- design/standard_timer.sv ----
`timescale 1ns/1ps
module standard_timer (
    input wire logic CLK, // system clock
    input wire logic SRST, // synchronous reset
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb enable
    input wire logic PWRITE, // apb direction
    input wire logic [stm_pkg::ADDR_W-1:0] PADDR, // apb address
    input wire logic [31:0] PWDATA, // apb write data
    output logic [31:0] PRDATA, // apb read data
    output logic PREADY, // apb ready
    output logic PSLVERR, // apb error
    input wire logic EXT_COUNT_CLOCK, // external count clock pin
    output logic TIMER_OUTPUT_PIN, // timer output level
    output logic TIMER_OUTPUT_PIN_EN // output enable
);
    import stm_pkg::*;

    // ========================================
    // register state
    logic pause_q;
    logic [2:0] cks_q;
    logic on_q;
    logic on_prev_q;
    mode_t mode_q;
    logic [1:0] fn_q;
    logic oc_q;
    logic pol_q;
    logic swap_q;
    logic cclr_q;
    logic [15:0] cmpa_q;
    logic [7:0] period_q;
    logic [15:0] cnt_q;
    logic flag_a_q;
    logic flag_p_q;
    logic pin_q;
    logic pready_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic out_q;
    logic out_en_q;

    // ========================================
    // apb slave
    logic acc_req;
    logic wr_en;
    logic addr_hit;
    logic [7:0] rd_byte;

    assign acc_req = PSEL && PENABLE && !pready_q;
    assign wr_en = PSEL && PENABLE && pready_q && PWRITE;

    always_comb begin
        addr_hit = 1'b1;
        rd_byte = BYTE_RST;
        unique case (PADDR)
            OFS_CTRL0: rd_byte = {pause_q, cks_q, on_q, 3'h0};
            OFS_CTRL1: rd_byte = {mode_q, fn_q, oc_q, pol_q, swap_q, cclr_q};
            OFS_CNT_LO: rd_byte = cnt_q[7:0];
            OFS_CNT_HI: rd_byte = cnt_q[15:8];
            OFS_CMPA_LO: rd_byte = cmpa_q[7:0];
            OFS_CMPA_HI: rd_byte = cmpa_q[15:8];
            OFS_PERIOD: rd_byte = period_q;
            OFS_STATUS: rd_byte = {6'h00, flag_p_q, flag_a_q};
            default: addr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= acc_req;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else if (acc_req) begin
            prdata_q <= PWRITE ? 32'h00000000 : {24'h000000, rd_byte};
            pslverr_q <= !addr_hit;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            pause_q <= 1'b0;
            cks_q <= CKS_SYS4;
            on_q <= 1'b0;
        end else if (wr_en && PADDR == OFS_CTRL0) begin
            pause_q <= PWDATA[C0_PAUSE];
            cks_q <= PWDATA[C0_CKS_LSB +: 3];
            on_q <= PWDATA[C0_ON];
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            mode_q <= MODE_CMP;
            fn_q <= FN_NONE;
            oc_q <= 1'b0;
            pol_q <= 1'b0;
            swap_q <= 1'b0;
            cclr_q <= 1'b0;
        end else if (wr_en && PADDR == OFS_CTRL1) begin
            mode_q <= mode_t'(PWDATA[C1_MODE_LSB +: 2]);
            fn_q <= PWDATA[C1_FN_LSB +: 2];
            oc_q <= PWDATA[C1_OC];
            pol_q <= PWDATA[C1_POL];
            swap_q <= PWDATA[C1_SWAP];
            cclr_q <= PWDATA[C1_CCLR];
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            cmpa_q <= WORD_RST;
            period_q <= BYTE_RST;
        end else if (wr_en) begin
            if (PADDR == OFS_CMPA_LO) begin
                cmpa_q[7:0] <= PWDATA[7:0];
            end
            if (PADDR == OFS_CMPA_HI) begin
                cmpa_q[15:8] <= PWDATA[7:0];
            end
            if (PADDR == OFS_PERIOD) begin
                period_q <= PWDATA[7:0];
            end
        end
    end

    // ========================================
    // count clock selection
    logic ext1_q;
    logic ext2_q;
    logic ext3_q;
    logic ext_lvl_q;
    logic ext_rise;
    logic ext_fall;
    logic [5:0] pre_q;
    logic [15:0] sub_q;
    logic sub_tick;
    logic tick;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            ext1_q <= 1'b0;
            ext2_q <= 1'b0;
            ext3_q <= 1'b0;
            ext_lvl_q <= 1'b0;
        end else begin
            ext1_q <= EXT_COUNT_CLOCK;
            ext2_q <= ext1_q;
            ext3_q <= ext2_q;
            if (ext2_q == ext3_q) begin
                ext_lvl_q <= ext3_q;
            end
        end
    end

    assign ext_rise = (ext2_q == ext3_q) && ext3_q && !ext_lvl_q;
    assign ext_fall = (ext2_q == ext3_q) && !ext3_q && ext_lvl_q;
    assign sub_tick = (sub_q == SUB_DIV_END);

    always_ff @(posedge CLK) begin
        if (SRST) begin
            pre_q <= 6'h00;
            sub_q <= WORD_RST;
        end else begin
            pre_q <= pre_q + 6'h01;
            sub_q <= sub_tick ? WORD_RST : sub_q + 16'h0001;
        end
    end

    always_comb begin
        tick = 1'b0;
        unique case (cks_q)
            CKS_SYS4: tick = (pre_q[1:0] == DIV4_END);
            CKS_SYS: tick = 1'b1;
            CKS_H16: tick = (pre_q[3:0] == DIV16_END);
            CKS_H64: tick = (pre_q == DIV64_END);
            CKS_SUB0: tick = sub_tick;
            CKS_SUB1: tick = sub_tick;
            CKS_EXTR: tick = ext_rise;
            CKS_EXTF: tick = ext_fall;
        endcase
    end

    // ========================================
    // counter and comparators
    logic on_rise;
    logic run_tick;
    logic cmp_like;
    logic pwm_mode;
    logic [15:0] cnt_inc;
    logic match_a;
    logic match_p;
    logic clr;
    logic set_a;
    logic set_p;

    assign on_rise = on_q && !on_prev_q;
    assign run_tick = on_q && !pause_q && tick;
    assign cmp_like = (mode_q == MODE_CMP) || (mode_q == MODE_TMR);
    assign pwm_mode = (mode_q == MODE_PWM);
    assign cnt_inc = cnt_q + 16'h0001;
    // A zero compare value never matches outside PWM
    assign match_a = run_tick && (cnt_inc == cmpa_q) && (cmpa_q != WORD_RST || pwm_mode);
    // period zero makes the match the overflow itself
    assign match_p = run_tick && (cnt_inc == {period_q, 8'h00});

    always_comb begin
        clr = match_p;
        if (cmp_like) begin
            clr = cclr_q ? match_a : match_p;
        end else if (pwm_mode) begin
            clr = swap_q ? match_a : match_p;
        end
    end

    assign set_a = match_a && (mode_q != MODE_CAP);
    assign set_p = match_p && (mode_q != MODE_CAP) && !(cmp_like && cclr_q);

    always_ff @(posedge CLK) begin
        if (SRST) begin
            on_prev_q <= 1'b0;
        end else begin
            on_prev_q <= on_q;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            cnt_q <= WORD_RST;
        end else if (on_rise) begin
            cnt_q <= WORD_RST;
        end else if (run_tick) begin
            cnt_q <= clr ? WORD_RST : cnt_inc;
        end
    end

    // set wins over a same-cycle clear
    always_ff @(posedge CLK) begin
        if (SRST) begin
            flag_a_q <= 1'b0;
            flag_p_q <= 1'b0;
        end else begin
            flag_a_q <= set_a || (flag_a_q && !(wr_en && PADDR == OFS_STATUS && PWDATA[ST_A]));
            flag_p_q <= set_p || (flag_p_q && !(wr_en && PADDR == OFS_STATUS && PWDATA[ST_P]));
        end
    end

    // ========================================
    // output pin
    logic [16:0] duty17;
    logic [16:0] per17;
    logic full_duty;
    logic pwm_active;
    logic pwm_lvl;
    logic out_d;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            pin_q <= 1'b0;
        end else if (on_rise) begin
            pin_q <= oc_q;
        end else if (set_a && mode_q == MODE_CMP) begin
            unique case (fn_q)
                FN_NONE: pin_q <= pin_q;
                FN_LOW: pin_q <= 1'b0;
                FN_HIGH: pin_q <= 1'b1;
                FN_TOGGLE: pin_q <= !pin_q;
            endcase
        end
    end

    always_comb begin
        if (swap_q) begin
            per17 = (cmpa_q == WORD_RST) ? FULL_SPAN : {1'b0, cmpa_q};
            duty17 = (period_q == BYTE_RST) ? FULL_SPAN : {1'b0, period_q, 8'h00};
        end else begin
            per17 = (period_q == BYTE_RST) ? FULL_SPAN : {1'b0, period_q, 8'h00};
            duty17 = {1'b0, cmpa_q};
        end
    end

    assign full_duty = (duty17 >= per17);
    assign pwm_active = full_duty || ({1'b0, cnt_q} < duty17);

    always_comb begin
        pwm_lvl = 1'b0;
        unique case (fn_q)
            FN_INACT: pwm_lvl = 1'b0;
            FN_ACT: pwm_lvl = 1'b1;
            FN_PWM: pwm_lvl = pwm_active;
            default: pwm_lvl = 1'b0;
        endcase
    end

    // active level then polarity inversion
    assign out_d = pol_q ^ (pwm_mode ? (oc_q ? pwm_lvl : !pwm_lvl) : pin_q);

    always_ff @(posedge CLK) begin
        if (SRST) begin
            out_q <= 1'b0;
            out_en_q <= 1'b0;
        end else begin
            out_q <= out_d;
            out_en_q <= (mode_q == MODE_CMP) || pwm_mode;
        end
    end

    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign TIMER_OUTPUT_PIN = out_q;
    assign TIMER_OUTPUT_PIN_EN = out_en_q;

    // ========================================
    // assertions
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    sequence s_access_wait;
        PSEL && PENABLE && !PREADY;
    endsequence
    sequence s_ready_one;
        PREADY ##1 !PREADY;
    endsequence

    a_apb_ready_one: assert property (s_access_wait |=> s_ready_one)
        else $error("apb ready not a single cycle");
    a_on_rise_clear: assert property (on_rise |=> cnt_q == 16'h0000)
        else $error("counter not cleared on enable");
    a_off_hold: assert property (!on_q && !on_rise |=> $stable(cnt_q))
        else $error("counter moved while off");
    a_pause_hold: assert property (on_q && on_prev_q && pause_q |=> $stable(cnt_q))
        else $error("counter moved while paused");
    a_count_step: assert property (run_tick && !clr && !on_rise |=> cnt_q == $past(cnt_inc))
        else $error("counter did not step by one");
    a_p_clear: assert property (cmp_like && !cclr_q && match_p && !on_rise |=> cnt_q == 16'h0000)
        else $error("period match did not clear counter");
    a_no_p_flag: assert property (cmp_like && cclr_q && !flag_p_q |=> !flag_p_q)
        else $error("period flag raised with A clear");
    a_a_zero_flag: assert property (cmp_like && cmpa_q == 16'h0000 && !flag_a_q |=> !flag_a_q)
        else $error("A flag raised with zero compare");
    a_flag_sticky: assert property (set_a |=> flag_a_q [*2] or (flag_a_q ##1 1'b1))
        else $error("A flag not set on match");
    a_flag_hold: assert property (flag_a_q && !wr_en |=> flag_a_q)
        else $error("A flag dropped without clear");
    a_timer_no_pin: assert property (mode_q == MODE_TMR |=> !TIMER_OUTPUT_PIN_EN)
        else $error("pin driven in timer mode");
    a_pwm_full: assert property (pwm_mode && fn_q == FN_PWM && full_duty
        |=> TIMER_OUTPUT_PIN == $past(pol_q ^ oc_q))
        else $error("full duty output not active");
    a_pin_enable_init: assert property (on_rise && mode_q == MODE_CMP ##1 !set_a
        |=> TIMER_OUTPUT_PIN == $past(oc_q ^ pol_q, 2))
        else $error("pin not at initial level after enable");
endmodule

// ---- sim/stm_far_side.sv ----
`timescale 1ns/1ps
// ========================================
// far side: pull-down pin load and count clock source
module stm_far_side (
    input wire logic clk, // system clock
    input wire logic pin, // timer output level
    input wire logic pin_en, // timer output enable
    output logic ext_clk, // count clock into the timer
    output logic pin_level // level seen on the pin
);
    // a released pin falls to the pull-down level
    assign pin_level = pin_en ? pin : 1'b0;
    initial ext_clk = 1'b0;
    // clock stands still low between bursts
    task automatic burst(input int n);
        repeat (n) begin
            @(posedge clk);
            ext_clk <= 1'b1;
            repeat (4) @(posedge clk);
            ext_clk <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
endmodule

// ---- sim/standard_timer_bench.sv ----
`timescale 1ns/1ps
module standard_timer_bench;
    import stm_pkg::*;
    typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] q; logic e;} reg_row_t;
    typedef struct {logic [7:0] c1; logic [7:0] ah; logic [7:0] al; int win; int exp;} pwm_row_t;
    logic CLK, SRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
    logic EXT_COUNT_CLOCK, TIMER_OUTPUT_PIN, TIMER_OUTPUT_PIN_EN, pin_level;
    logic [7:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd, prev;
    int n_fail = 0;
    int num_checks = 0;
    int h;
    logic [2:0] sels [6] = '{3'h1, 3'h0, 3'h2, 3'h3, 3'h4, 3'h5};
    int divs [6] = '{1, 4, 16, 64, 1000, 1000};
    int ticks [6] = '{40, 40, 40, 40, 3, 3};
    reg_row_t rows [16] = '{
        '{1'b0, OFS_CNT_LO, 8'h00, 8'h00, 1'b0}, '{1'b0, OFS_CNT_HI, 8'h00, 8'h00, 1'b0},
        '{1'b0, OFS_CMPA_LO, 8'h00, 8'h00, 1'b0}, '{1'b0, OFS_CMPA_HI, 8'h00, 8'h00, 1'b0},
        '{1'b0, OFS_PERIOD, 8'h00, 8'h00, 1'b0}, '{1'b0, OFS_STATUS, 8'h00, 8'h00, 1'b0},
        '{1'b1, OFS_CMPA_LO, 8'hA5, 8'h00, 1'b0}, '{1'b0, OFS_CMPA_LO, 8'h00, 8'hA5, 1'b0},
        '{1'b1, OFS_CMPA_HI, 8'h5A, 8'h00, 1'b0}, '{1'b0, OFS_CMPA_HI, 8'h00, 8'h5A, 1'b0},
        '{1'b1, OFS_PERIOD, 8'h3C, 8'h00, 1'b0}, '{1'b0, OFS_PERIOD, 8'h00, 8'h3C, 1'b0},
        '{1'b1, OFS_CNT_LO, 8'hFF, 8'h00, 1'b0}, '{1'b0, OFS_CNT_LO, 8'h00, 8'h00, 1'b0},
        '{1'b1, 8'h20, 8'hFF, 8'h00, 1'b1}, '{1'b0, 8'h20, 8'h00, 8'h00, 1'b1}};
    pwm_row_t pwm [8] = '{
        '{8'hA8, 8'h00, 8'h40, 256, 64}, '{8'hA9, 8'h00, 8'h40, 256, 64},
        '{8'hAC, 8'h00, 8'h40, 256, 192}, '{8'hA0, 8'h00, 8'h40, 256, 192},
        '{8'h88, 8'h00, 8'h40, 256, 0}, '{8'h98, 8'h00, 8'h40, 256, 256},
        '{8'hA8, 8'h02, 8'h00, 256, 256}, '{8'hAA, 8'h02, 8'h00, 512, 256}};

    standard_timer dut (.CLK(CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .EXT_COUNT_CLOCK(EXT_COUNT_CLOCK),
        .TIMER_OUTPUT_PIN(TIMER_OUTPUT_PIN), .TIMER_OUTPUT_PIN_EN(TIMER_OUTPUT_PIN_EN));
    stm_far_side u_far (.clk(CLK), .pin(TIMER_OUTPUT_PIN), .pin_en(TIMER_OUTPUT_PIN_EN),
        .ext_clk(EXT_COUNT_CLOCK), .pin_level(pin_level));

    initial begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= {24'h000000, d};
        @(posedge CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        if (n >= 20) n_fail++;
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic restart(input logic [7:0] c1, input logic [7:0] c0);
        xfer(1'b1, OFS_CTRL0, 8'h00);
        xfer(1'b1, OFS_CTRL1, c1);
        xfer(1'b1, OFS_CTRL0, c0);
    endtask

    task automatic highs(input int win, output int cnt);
        cnt = 0;
        repeat (win) begin
            @(posedge CLK);
            #1;
            if (pin_level === 1'b1) cnt++;
        end
    endtask

    task automatic print_verdict;
        $display("checks=%0d fails=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (95000) @(posedge CLK);
        n_fail++;
        print_verdict;
    end

    initial begin
        SRST = 1'b1;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 8'h00;
        PWDATA = 32'h00000000;
        repeat (8) @(posedge CLK);
        SRST <= 1'b0;
        foreach (rows[i]) begin
            xfer(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) check(rd, {24'h000000, rows[i].q});
            check(err, rows[i].e);
        end
        // clear on A match, P match below A must stay silent
        xfer(1'b1, OFS_CMPA_HI, 8'h02);
        xfer(1'b1, OFS_CMPA_LO, 8'h00);
        xfer(1'b1, OFS_PERIOD, 8'h01);
        restart(8'h39, 8'h18);
        repeat (4) @(posedge CLK);
        check(TIMER_OUTPUT_PIN, 32'h1);
        repeat (600) @(posedge CLK);
        xfer(1'b0, OFS_STATUS, 8'h00);
        check(rd, 32'h1);
        check(TIMER_OUTPUT_PIN, 32'h0);
        xfer(1'b0, OFS_CNT_HI, 8'h00);
        check(rd, 32'h0);
        xfer(1'b1, OFS_STATUS, 8'h03);
        xfer(1'b0, OFS_STATUS, 8'h00);
        check(rd, 32'h0);
        // clear on P match, pin set high by A only
        xfer(1'b1, OFS_CMPA_LO, 8'h80);
        xfer(1'b1, OFS_CMPA_HI, 8'h00);
        xfer(1'b1, OFS_PERIOD, 8'h02);
        restart(8'h20, 8'h18);
        check(TIMER_OUTPUT_PIN, 32'h0);
        repeat (296) @(posedge CLK);
        xfer(1'b0, OFS_STATUS, 8'h00);
        check(rd, 32'h1);
        xfer(1'b0, OFS_CNT_HI, 8'h00);
        check(rd, 32'h1);
        check(TIMER_OUTPUT_PIN, 32'h1);
        repeat (250) @(posedge CLK);
        xfer(1'b0, OFS_STATUS, 8'h00);
        check(rd, 32'h3);
        xfer(1'b0, OFS_CNT_HI, 8'h00);
        check(rd, 32'h0);
        check(TIMER_OUTPUT_PIN, 32'h1);
        // pause and off hold the count, on restarts from zero
        xfer(1'b1, OFS_CTRL0, 8'h98);
        xfer(1'b0, OFS_CNT_LO, 8'h00);
        prev = rd;
        repeat (20) @(posedge CLK);
        xfer(1'b0, OFS_CNT_LO, 8'h00);
        check(rd, prev);
        xfer(1'b1, OFS_CTRL0, 8'h18);
        repeat (10) @(posedge CLK);
        xfer(1'b0, OFS_CNT_LO, 8'h00);
        check(rd !== prev, 32'h1);
        xfer(1'b1, OFS_CTRL0, 8'h10);
        xfer(1'b0, OFS_CNT_LO, 8'h00);
        prev = rd;
        repeat (20) @(posedge CLK);
        xfer(1'b0, OFS_CNT_LO, 8'h00);
        check(rd, prev);
        xfer(1'b1, OFS_CTRL0, 8'h18);
        xfer(1'b0, OFS_CNT_LO, 8'h00);
        check(rd < 32'h10, 32'h1);
        // timer mode: pin released, overflow with A zero raises no A flag
        restart(8'hC0, 8'h00);
        xfer(1'b1, OFS_CMPA_LO, 8'h00);
        xfer(1'b1, OFS_PERIOD, 8'h00);
        restart(8'hC0, 8'h18);
        xfer(1'b1, OFS_STATUS, 8'h03);
        check(TIMER_OUTPUT_PIN_EN, 32'h0);
        repeat (65600) @(posedge CLK);
        xfer(1'b0, OFS_STATUS, 8'h00);
        check(rd, 32'h2);
        xfer(1'b0, OFS_CNT_HI, 8'h00);
        check(rd, 32'h0);
        for (int i = 0; i < 6; i++) begin
            restart(8'hC0, {1'b0, sels[i], 4'h8});
            repeat (divs[i] * ticks[i]) @(posedge CLK);
            xfer(1'b0, OFS_CNT_LO, 8'h00);
            check(rd >= ticks[i] && rd <= ticks[i] + 8, 32'h1);
        end
        restart(8'hC0, 8'h68);
        u_far.burst(40);
        repeat (8) @(posedge CLK);
        xfer(1'b0, OFS_CNT_LO, 8'h00);
        check(rd, 32'd40);
        restart(8'hC0, 8'h78);
        u_far.burst(40);
        repeat (8) @(posedge CLK);
        xfer(1'b0, OFS_CNT_LO, 8'h00);
        check(rd, 32'd40);
        // waveform duty over whole periods
        xfer(1'b1, OFS_PERIOD, 8'h01);
        foreach (pwm[i]) begin
            xfer(1'b1, OFS_CMPA_HI, pwm[i].ah);
            xfer(1'b1, OFS_CMPA_LO, pwm[i].al);
            restart(pwm[i].c1, 8'h18);
            repeat (8) @(posedge CLK);
            highs(pwm[i].win, h);
            check(h, pwm[i].exp);
        end
        xfer(1'b1, OFS_CMPA_LO, 8'h40);
        xfer(1'b1, OFS_CMPA_HI, 8'h00);
        restart(8'h88, 8'h18);
        xfer(1'b1, OFS_STATUS, 8'h03);
        repeat (300) @(posedge CLK);
        xfer(1'b0, OFS_STATUS, 8'h00);
        check(rd, 32'h3);
        // capture mode counts but raises no flags
        restart(8'h40, 8'h18);
        xfer(1'b1, OFS_STATUS, 8'h03);
        repeat (300) @(posedge CLK);
        xfer(1'b0, OFS_STATUS, 8'h00);
        check(rd, 32'h0);
        // reset in mid-run brings registers back to zero
        SRST <= 1'b1;
        repeat (2) @(posedge CLK);
        SRST <= 1'b0;
        xfer(1'b0, OFS_CNT_LO, 8'h00);
        check(rd, 32'h0);
        xfer(1'b0, OFS_CMPA_LO, 8'h00);
        check(rd, 32'h0);
        print_verdict;
    end
endmodule
